// [rtl/tsp_pkg.sv]
// Purpose: Constants for the TDM serial port control block
// Assumes: 32-bit register port, ref_clk domain
// Notes: Offsets are byte addresses
package tsp_pkg;
	localparam logic [11:0] TSP_OFS_CTRL = 12'h1d8;
	localparam logic [11:0] TSP_OFS_DMA = 12'h1f0;
	localparam logic [11:0] TSP_OFS_TXD = 12'h1f4;
	localparam logic [11:0] TSP_OFS_RXD = 12'h1f8;
	localparam logic [11:0] TSP_OFS_STAT = 12'h1fc;
	localparam int TSP_B_LOOP = 29;
	localparam int TSP_B_TEST = 28;
	localparam int TSP_B_FSDIR = 27;
	localparam int TSP_B_FSW = 25;
	localparam int TSP_B_NCH = 20;
	localparam int TSP_B_TXOFF = 16;
	localparam int TSP_B_RXOFF = 12;
	localparam int TSP_B_TXMSB = 11;
	localparam int TSP_B_RXMSB = 10;
	localparam int TSP_B_INPOL = 9;
	localparam int TSP_B_OUTPOL = 8;
	localparam int TSP_B_RXEDGE = 7;
	localparam int TSP_B_TXEDGE = 6;
	localparam int TSP_B_FSEDGE = 5;
	localparam int TSP_B_FSLEDGE = 4;
	localparam int TSP_B_X2 = 3;
	localparam int TSP_B_RXEN = 2;
	localparam int TSP_B_TXEN = 1;
	localparam int TSP_B_EN = 0;
	localparam int TSP_B_RXDMA = 0;
	localparam int TSP_B_TXDMA = 1;
	localparam int TSP_B_RXVALID = 8;
	localparam int TSP_B_RXCNT = 16;
	localparam logic [31:0] TSP_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] TSP_CTRL_MASK = 32'h3fff_ffff;
	localparam logic [11:0] TSP_CNT_MAX = 12'hfff;
	typedef enum logic [1:0] {
		TSP_W_BIT = 2'b00,
		TSP_W_TWO = 2'b01,
		TSP_W_BYTE = 2'b10,
		TSP_W_HALF = 2'b11
	} tsp_width_t;
endpackage

// [rtl/tsp_top.sv]
// Purpose: TDM serial port control, sync, serialiser and deserialiser
// Assumes: Serial clock, sync and data pins are sampled by ref_clk
// Notes: Serial clock must be well below a quarter of ref_clk
// Function
// - Loopback feeds inverted transmit data to receive, else serial_in; test bit unused.
// - sync_direction one drives frame_sync out as master, zero makes it input.
// - Master sync pulse width is one bit, two bits, one byte or half-frame.
// - Double rate mode uses two serial clock periods per data bit.
// - Timeslots per half-frame equal channels_per_half_frame plus one, up to 32.
// - Transmit timeslot 0 starts tx_bit_offset clocks after frame start edge.
// - Receive timeslot 0 capture starts rx_bit_offset clocks after frame start edge.
// - Transmit bytes go out MSB first when tx_bit_order is one, else LSB.
// - First received bit is MSB when rx_bit_order is one, else LSB.
// - sync_in_polarity one means active low sync, frame starts on falling edge.
// - Master sync drives active low when sync_out_polarity is one, else high.
// - serial_in sampled on rising clock edge when rx_sample_edge one, else falling.
// - serial_out launched on rising clock edge when tx_launch_edge one, else falling.
// - frame_sync sampled on rising edge when sync_sample_edge one, else falling.
// - Master sync launched on rising edge when sync_launch_edge one, else falling.
// - Receive processed only with rx_cpu_enable, unless receive DMA is enabled.
// - Transmit only with tx_cpu_enable, else serial_out tri-stated, unless transmit DMA.
// - port_enable zero holds port logic in reset, control register untouched.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
module tsp_top
	import tsp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic serial_clock_pin,
	input wire logic frame_sync_in,
	output logic frame_sync_out,
	output logic frame_sync_oe,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe
);
	logic [31:0] ctrl_reg;
	logic [1:0] dma_reg;
	logic [7:0] tx_hold_reg;
	logic [7:0] rx_data_reg;
	logic rx_valid_reg;
	logic [7:0] rx_count_reg;
	logic [7:0] frame_count_reg;
	logic [2:0] sclk_sync_reg;
	logic [1:0] fs_sync_reg;
	logic [1:0] din_sync_reg;
	logic fs_samp_reg;
	logic fs_prev_reg;
	logic [11:0] clk_cnt_reg;
	logic framed_reg;
	logic [11:0] mst_cnt_reg;
	logic [7:0] rx_shift_reg;
	logic [31:0] rdata_next;

	// Control fields
	logic loop_sel;
	logic sync_dir;
	logic tx_msb;
	logic rx_msb;
	logic in_pol;
	logic out_pol;
	logic rx_edge;
	logic tx_edge;
	logic fs_edge;
	logic fsl_edge;
	logic dbl;
	logic port_en;
	logic [1:0] fs_width;
	logic [4:0] nchan;
	logic [3:0] tx_off;
	logic [3:0] rx_off;
	assign loop_sel = ctrl_reg[TSP_B_LOOP];
	assign sync_dir = ctrl_reg[TSP_B_FSDIR];
	assign fs_width = ctrl_reg[TSP_B_FSW +: 2];
	assign nchan = ctrl_reg[TSP_B_NCH +: 5];
	assign tx_off = ctrl_reg[TSP_B_TXOFF +: 4];
	assign rx_off = ctrl_reg[TSP_B_RXOFF +: 4];
	assign tx_msb = ctrl_reg[TSP_B_TXMSB];
	assign rx_msb = ctrl_reg[TSP_B_RXMSB];
	assign in_pol = ctrl_reg[TSP_B_INPOL];
	assign out_pol = ctrl_reg[TSP_B_OUTPOL];
	assign rx_edge = ctrl_reg[TSP_B_RXEDGE];
	assign tx_edge = ctrl_reg[TSP_B_TXEDGE];
	assign fs_edge = ctrl_reg[TSP_B_FSEDGE];
	assign fsl_edge = ctrl_reg[TSP_B_FSLEDGE];
	assign dbl = ctrl_reg[TSP_B_X2];
	assign port_en = ctrl_reg[TSP_B_EN];

	// Selects the rising or falling serial clock edge
	function automatic logic edge_hit(input logic sel, input logic rise, input logic fall);
		edge_hit = sel ? rise : fall;
	endfunction

	// Scales a count of data bits into serial clocks
	function automatic logic [11:0] bits_to_clk(input logic [11:0] nbits, input logic x2);
		bits_to_clk = x2 ? {nbits[10:0], 1'b0} : nbits;
	endfunction

	logic sclk_rise;
	logic sclk_fall;
	assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];

	logic rx_on;
	assign rx_on = ctrl_reg[TSP_B_RXEN] | dma_reg[TSP_B_RXDMA];
	logic tx_on;
	assign tx_on = ctrl_reg[TSP_B_TXEN] | dma_reg[TSP_B_TXDMA];

	logic [11:0] half_bits;
	logic [11:0] frame_bits;
	logic [11:0] half_clk;
	logic [11:0] frame_clk;
	assign half_bits = {1'b0, ({3'h0, nchan} + 8'h01), 3'h0};
	assign frame_bits = {half_bits[10:0], 1'b0};
	assign half_clk = bits_to_clk(half_bits, dbl);
	assign frame_clk = bits_to_clk(frame_bits, dbl);

	logic [11:0] width_clk;
	always_comb begin
		case (tsp_width_t'(fs_width))
			TSP_W_BIT: width_clk = bits_to_clk(12'h001, dbl);
			TSP_W_TWO: width_clk = bits_to_clk(12'h002, dbl);
			TSP_W_BYTE: width_clk = bits_to_clk(12'h008, dbl);
			TSP_W_HALF: width_clk = half_clk;
			default: width_clk = bits_to_clk(12'h001, dbl);
		endcase
	end

	// Pin synchronisers, one per pin
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sclk_sync_reg <= 3'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], serial_clock_pin};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			fs_sync_reg <= 2'h0;
		end else begin
			fs_sync_reg <= {fs_sync_reg[0], frame_sync_in};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			din_sync_reg <= 2'h0;
		end else begin
			din_sync_reg <= {din_sync_reg[0], serial_in};
		end
	end

	// Register writes
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ctrl_reg <= TSP_CTRL_RST;
		end else if (reg_write && reg_addr == TSP_OFS_CTRL) begin
			ctrl_reg <= reg_wdata & TSP_CTRL_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			dma_reg <= 2'h0;
		end else if (reg_write && reg_addr == TSP_OFS_DMA) begin
			dma_reg <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			tx_hold_reg <= 8'h00;
		end else if (reg_write && reg_addr == TSP_OFS_TXD) begin
			tx_hold_reg <= reg_wdata[7:0];
		end
	end

	// Register reads
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (reg_addr)
			TSP_OFS_CTRL: rdata_next = ctrl_reg;
			TSP_OFS_DMA: rdata_next = {30'h0, dma_reg};
			TSP_OFS_TXD: rdata_next = {24'h0, tx_hold_reg};
			TSP_OFS_RXD: rdata_next = {8'h0, rx_count_reg, 7'h0, rx_valid_reg, rx_data_reg};
			TSP_OFS_STAT: rdata_next = {16'h0, frame_count_reg, 6'h0, fs_samp_reg, framed_reg};
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_read ? rdata_next : 32'h0000_0000;
		end
	end

	logic fs_act;
	logic frame_start;
	assign fs_act = fs_sync_reg[1] ^ in_pol;
	assign frame_start = port_en & edge_hit(fs_edge, sclk_rise, sclk_fall) & fs_act & ~fs_prev_reg;
	always_ff @(posedge ref_clk) begin
		if (!resetn || !port_en) begin
			fs_samp_reg <= 1'b0;
			fs_prev_reg <= 1'b1;
		end else if (edge_hit(fs_edge, sclk_rise, sclk_fall)) begin
			fs_samp_reg <= fs_act;
			fs_prev_reg <= fs_act;
		end
	end

	// Serial clocks since frame start
	always_ff @(posedge ref_clk) begin
		if (!resetn || !port_en) begin
			clk_cnt_reg <= 12'h000;
		end else if (frame_start) begin
			clk_cnt_reg <= 12'h000;
		end else if (sclk_rise && clk_cnt_reg != TSP_CNT_MAX) begin
			clk_cnt_reg <= clk_cnt_reg + 12'h001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn || !port_en) begin
			framed_reg <= 1'b0;
		end else if (frame_start) begin
			framed_reg <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn || !port_en) begin
			frame_count_reg <= 8'h00;
		end else if (frame_start) begin
			frame_count_reg <= frame_count_reg + 8'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn || !port_en) begin
			mst_cnt_reg <= 12'h000;
			frame_sync_out <= 1'b0;
			frame_sync_oe <= 1'b0;
		end else begin
			frame_sync_oe <= sync_dir;
			if (sync_dir && edge_hit(fsl_edge, sclk_rise, sclk_fall)) begin
				frame_sync_out <= (mst_cnt_reg < width_clk) ^ out_pol;
				if (mst_cnt_reg >= frame_clk - 12'h001) begin
					mst_cnt_reg <= 12'h000;
				end else begin
					mst_cnt_reg <= mst_cnt_reg + 12'h001;
				end
			end else if (!sync_dir) begin
				frame_sync_out <= out_pol;
			end
		end
	end

	logic [11:0] tx_pos;
	logic [11:0] tx_bit;
	logic tx_in_frame;
	assign tx_pos = clk_cnt_reg - {8'h00, tx_off};
	assign tx_bit = dbl ? {1'b0, tx_pos[11:1]} : tx_pos;
	assign tx_in_frame = framed_reg & (clk_cnt_reg >= {8'h00, tx_off}) & (tx_bit < frame_bits);

	always_ff @(posedge ref_clk) begin
		if (!resetn || !port_en) begin
			serial_out <= 1'b0;
			serial_out_oe <= 1'b0;
		end else begin
			serial_out_oe <= tx_on;
			if (tx_on && tx_in_frame && edge_hit(tx_edge, sclk_rise, sclk_fall)) begin
				serial_out <= tx_hold_reg[tx_msb ? 3'h7 - tx_bit[2:0] : tx_bit[2:0]];
			end
		end
	end

	logic rx_src;
	assign rx_src = loop_sel ? ~serial_out : din_sync_reg[1];

	logic [11:0] rx_pos;
	logic [11:0] rx_bit;
	logic rx_in_frame;
	logic rx_take;
	assign rx_pos = clk_cnt_reg - {8'h00, rx_off};
	assign rx_bit = dbl ? {1'b0, rx_pos[11:1]} : rx_pos;
	assign rx_in_frame = framed_reg & (clk_cnt_reg >= {8'h00, rx_off}) & (rx_bit < frame_bits);
	assign rx_take = rx_on & rx_in_frame & (~dbl | rx_pos[0]) & edge_hit(rx_edge, sclk_rise, sclk_fall);

	logic [2:0] rx_idx;
	logic [7:0] rx_asm;
	always_comb begin
		rx_idx = rx_msb ? 3'h7 - rx_bit[2:0] : rx_bit[2:0];
		rx_asm = rx_shift_reg;
		rx_asm[rx_idx] = rx_src;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn || !port_en) begin
			rx_shift_reg <= 8'h00;
		end else if (rx_take) begin
			rx_shift_reg <= rx_asm;
		end
	end

	// Received byte holding; a new byte wins over a read clear
	logic rx_done;
	logic rx_clr;
	assign rx_done = rx_take & (rx_bit[2:0] == 3'h7);
	assign rx_clr = reg_read & (reg_addr == TSP_OFS_RXD);
	always_ff @(posedge ref_clk) begin
		if (!resetn || !port_en) begin
			rx_data_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
			rx_count_reg <= 8'h00;
		end else if (rx_done) begin
			rx_data_reg <= rx_asm;
			rx_valid_reg <= 1'b1;
			rx_count_reg <= rx_count_reg + 8'h01;
		end else if (rx_clr) begin
			rx_valid_reg <= 1'b0;
		end
	end
endmodule // tsp_top

// [verif/tsp_codec.sv]
// Purpose: Far-side codec model for the serial port
// Assumes: Codec owns the serial clock
// Notes: Sync held inactive when the port is slave
`timescale 1ns/1ns
module tsp_codec (
	input wire logic run,
	input wire logic fs_oe,
	input wire logic fs_out,
	output logic sclk,
	output logic fs_wire,
	output logic sdin
);
	// Clock phase kept apart from ref_clk
	initial begin
		sclk = 1'b0;
		sdin = 1'b0;
		#7;
		forever begin
			#80 sclk = run ? ~sclk : 1'b0;
		end
	end
	always @(negedge sclk) begin
		sdin <= ~sdin;
	end
	assign fs_wire = fs_oe ? fs_out : 1'b0;
endmodule // tsp_codec

// [verif/tsp_top_sva.sv]
// Purpose: Port checks for the serial port control block
// Assumes: Only top ports are visible
// Notes: Enables are shadowed from bus writes
`timescale 1ns/1ns
module tsp_top_sva
	import tsp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic serial_clock_pin,
	input wire logic frame_sync_in,
	input wire logic frame_sync_out,
	input wire logic frame_sync_oe,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	logic [31:0] ctrl_reg;
	logic [1:0] dma_reg;
	logic tx_any;
	assign tx_any = ctrl_reg[TSP_B_TXEN] | dma_reg[TSP_B_TXDMA];
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ctrl_reg <= 32'h0;
		end else if (reg_write && reg_addr == TSP_OFS_CTRL) begin
			ctrl_reg <= reg_wdata & TSP_CTRL_MASK;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			dma_reg <= 2'h0;
		end else if (reg_write && reg_addr == TSP_OFS_DMA) begin
			dma_reg <= reg_wdata[1:0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	rd_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0) else $error("read data outside slot");
	ctrl_rd_a: assert property ($past(reg_read) && $past(reg_addr) == TSP_OFS_CTRL |->
		reg_rdata == $past(ctrl_reg)) else $error("control readback wrong");
	unmap_rd_a: assert property ($past(reg_read) && $past(reg_addr) == 12'h000 |-> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	fs_in_a: assert property (!ctrl_reg[TSP_B_FSDIR] && !$past(ctrl_reg[TSP_B_FSDIR]) |-> !frame_sync_oe)
		else $error("sync driven as slave");
	fs_out_a: assert property ($rose(ctrl_reg[TSP_B_EN]) && ctrl_reg[TSP_B_FSDIR] |-> ##[1:3] frame_sync_oe)
		else $error("sync not driven as master");
	off_quiet_a: assert property (!ctrl_reg[TSP_B_EN] && !$past(ctrl_reg[TSP_B_EN]) |->
		!frame_sync_oe && !serial_out_oe) else $error("pins driven while disabled");
	tx_tri_a: assert property (!tx_any && !$past(tx_any) |-> !serial_out_oe) else $error("data driven untransmit");
	tx_on_a: assert property ((tx_any && ctrl_reg[TSP_B_EN]) [*2] |-> serial_out_oe)
		else $error("data not driven");
endmodule // tsp_top_sva
bind tsp_top tsp_top_sva i_tsp_top_sva(.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
	.reg_rdata, .serial_clock_pin, .frame_sync_in, .frame_sync_out, .frame_sync_oe, .serial_in,
	.serial_out, .serial_out_oe);

// [verif/tsp_top_tb.sv]
// Purpose: Self-checking bench for the serial port control block
// Assumes: Codec model makes the serial clock
// Notes: Loopback supplies received bytes
`timescale 1ns/1ns
module tsp_top_tb;
	import tsp_pkg::*;
	logic ref_clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, run = 1'b0;
	logic [11:0] reg_addr = 12'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
	logic sclk, fs_wire, sdin, fs_out, fs_oe, sout, sout_oe;
	int mismatches = 0, n_compared = 0, cnt;
	always #10 ref_clk = ~ref_clk;
	tsp_top i_tsp_top(.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.serial_clock_pin(sclk), .frame_sync_in(fs_wire), .frame_sync_out(fs_out), .frame_sync_oe(fs_oe),
		.serial_in(sdin), .serial_out(sout), .serial_out_oe(sout_oe));
	tsp_codec i_tsp_codec(.run, .fs_oe, .fs_out, .sclk, .fs_wire, .sdin);
	task automatic results();
		if (mismatches == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge ref_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	task automatic master(input int i);
		logic [31:0] cfg;
		int f;
		cfg = 32'h0810_0010 | (32'(i) << TSP_B_FSW) | (i[0] ? 32'h300 : 32'h0) | (i == 3 ? 32'h8 : 32'h0);
		f = (i == 3) ? 64 : 32;
		wr(TSP_OFS_CTRL, cfg);
		wr(TSP_OFS_CTRL, cfg | 32'h1);
		repeat (3 * f) @(posedge sclk);
		cnt = 0;
		repeat (f) begin
			@(posedge sclk);
			cnt += int'((fs_out ^ i[0]) & fs_oe);
		end
		chk("sync width", cnt, (i == 3) ? 32 : (i == 2) ? 8 : i + 1);
		chk("sync drive", fs_oe, 1);
		wr(TSP_OFS_CTRL, cfg);
	endtask
	task automatic loop(input int i);
		logic [31:0] cfg;
		logic [7:0] e;
		cfg = 32'h2800_1050 | (32'(i & 3) << TSP_B_RXMSB);
		e = (i[1] == i[0]) ? 8'hfe : 8'h7f;
		wr(TSP_OFS_TXD, 32'h1);
		wr(TSP_OFS_CTRL, cfg);
		wr(TSP_OFS_CTRL, cfg | ((i == 4) ? 32'h2 : 32'h6));
		wr(TSP_OFS_CTRL, cfg | ((i == 4) ? 32'h3 : 32'h7));
		repeat (40) @(posedge sclk);
		rd(TSP_OFS_RXD);
		chk("rx byte", rd_val[8:0], (i == 4) ? 9'h0 : {1'b1, e});
		rd(TSP_OFS_STAT);
		chk("framed", rd_val[0], 1'b1);
		wr(TSP_OFS_CTRL, cfg);
	endtask
	initial begin
		#400000;
		mismatches++;
		results();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		run <= 1'b1;
		rd(TSP_OFS_CTRL);
		chk("ctrl reset", rd_val, TSP_CTRL_RST);
		wr(TSP_OFS_CTRL, 32'hffff_fffe);
		rd(TSP_OFS_CTRL);
		chk("ctrl rw", rd_val, 32'h3fff_fffe);
		rd(12'h000);
		chk("unmapped", rd_val, 0);
		for (int i = 0; i < 4; i++) begin
			master(i);
		end
		for (int i = 0; i < 5; i++) begin
			loop(i);
		end
		wr(TSP_OFS_CTRL, 32'h0);
		wr(TSP_OFS_CTRL, 32'h1);
		repeat (4) @(posedge ref_clk);
		chk("slave sync", fs_oe, 0);
		chk("tx off", sout_oe, 0);
		wr(TSP_OFS_CTRL, 32'h0);
		wr(TSP_OFS_DMA, 32'h2);
		wr(TSP_OFS_CTRL, 32'h1);
		repeat (4) @(posedge ref_clk);
		chk("dma tx", sout_oe, 1);
		wr(TSP_OFS_CTRL, 32'h0);
		wr(TSP_OFS_DMA, 32'h0);
		results();
	end
endmodule // tsp_top_tb
